// *** rtl/equalizer_filter_pkg.sv ***
// equalizer_filter_pkg: shared constants, field layouts and carriers
// for the equalizer filter configuration block and its output FIFO.
// assumes a 32-bit AHB-Lite register bus and 12-bit sample pairs.
package equalizer_filter_pkg;
  // bus and data widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  // register indices as printed; byte address is four times the index
  localparam logic [ADDR_W-1:0] CONFIG_INDEX = 16'h0400;
  localparam logic [ADDR_W-1:0] TAP0_INDEX = 16'h0418;
  localparam logic [ADDR_W-1:0] TAP1_INDEX = 16'h041a;
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = CONFIG_INDEX << 2;
  localparam logic [ADDR_W-1:0] TAP0_ADDR = TAP0_INDEX << 2;
  localparam logic [ADDR_W-1:0] TAP1_ADDR = TAP1_INDEX << 2;
  // coefficient windows and status word
  localparam logic [ADDR_W-1:0] COEF_A_BASE = 16'h1100;
  localparam logic [ADDR_W-1:0] COEF_B_BASE = 16'h1200;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'h1300;
  localparam int COEF_STRIDE_SHIFT = 2;
  // filter geometry
  localparam int SAMPLE_W = 12;
  localparam int TAP_COUNT = 9;
  localparam int CENTRE_TAP = 4;
  localparam int SIDE_COEF_W = 12;
  localparam int CENTRE_COEF_W = 18;
  localparam int COEF_STORE_W = 24;
  localparam int FRAC_BITS = 16;
  localparam int ACC_W = 40;
  localparam int SAMPLE_MAX = 2047;
  localparam int SAMPLE_MIN = -2048;
  // register masks and reset values
  localparam logic [COEF_STORE_W-1:0] SIDE_REG_MASK = 24'h00ffff;
  localparam logic [COEF_STORE_W-1:0] CENTRE_REG_MASK = 24'hffffff;
  localparam logic [COEF_STORE_W-1:0] COEF_RESET = 24'h000000;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // mode field encodings
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_ENABLED = 2'h2;
  // status word field positions
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_MERGE_BIT = 1;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_LEVEL_LSB = 8;

  // configuration byte layout, msb first
  typedef struct packed {
    logic reserved;
    logic coef_share_enable;
    logic filter_merge_enable;
    logic [2:0] side_coef_weight;
    logic [1:0] filter_mode_select;
  } filter_config_type;

  // one a/b sample pair per stream beat
  typedef struct packed {
    logic [SAMPLE_W-1:0] b;
    logic [SAMPLE_W-1:0] a;
  } sample_pair_type;

  typedef enum logic [1:0] {bus_idle, bus_write, bus_read} bus_state_type;
endpackage : equalizer_filter_pkg

// *** rtl/sample_fifo.sv ***
// sample_fifo: synchronous FIFO with registered flags.
// assumes one clock; depth is a power of two.
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH]; // storage flops
  logic [PTR_W-1:0] wr_ptr_reg; // next write slot
  logic [PTR_W-1:0] rd_ptr_reg; // oldest word
  logic [CNT_W-1:0] count_reg; // words held
  logic [CNT_W-1:0] count_next;
  logic in_ready_reg; // not full
  logic out_valid_reg; // not empty
  logic push;
  logic pop;

  assign push = in_valid && in_ready_reg;
  assign pop = out_valid_reg && out_ready;

  // occupancy after this edge
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CNT_W'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CNT_W'(1);
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap naturally at a power-of-two depth
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
      end
    end
  end

  // flags registered so both ready and valid leave from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready_reg <= (count_next != CNT_W'(DEPTH));
      out_valid_reg <= (count_next != '0);
    end
  end

  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = mem[rd_ptr_reg];
  assign level = count_reg;
endmodule : sample_fifo
`default_nettype wire

// *** rtl/programmable_fir_equalizer_cfg.sv ***
// programmable_fir_equalizer_cfg: register file and nine-tap equalizer
// on a/b sample pairs, results buffered in an output FIFO.
// assumes AHB-Lite single-word transfers, one slave, one clock domain.
// Operation
// - share bit makes channel b use a coefficients
// - merge bit joins both filters, one stream
// - side weight scales all non-centre taps
// - mode two enables, others bypass filter
// - side tap holds 12-bit signed value
// - tap register zero is first tap
// - tap register one is second tap
// - nine taps, centre tap eighteen bits
`timescale 1ns/1ns
`default_nettype none
module programmable_fir_equalizer_cfg #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // sample stream in
  input wire logic in_valid,
  input wire equalizer_filter_pkg::sample_pair_type in_data,
  output logic in_ready,
  // filtered stream out
  output logic out_valid,
  output equalizer_filter_pkg::sample_pair_type out_data,
  input wire logic out_ready,
  // serial link state, same clock
  input wire logic serial_link_enable
);
  // short local names for package geometry
  // keep the long expressions below readable
  localparam int SW = equalizer_filter_pkg::SAMPLE_W;
  localparam int TN = equalizer_filter_pkg::TAP_COUNT;
  localparam int CW = equalizer_filter_pkg::COEF_STORE_W;
  localparam int AW = equalizer_filter_pkg::ADDR_W;
  localparam int LVL_W = $clog2(FIFO_DEPTH+1);
  localparam int IDX_W = 4;

  // register file
  // all registers reset to zero: filter bypassed
  equalizer_filter_pkg::filter_config_type filter_config_reg; // mode, weight, merge, share
  logic [CW-1:0] coef_a_reg [TN]; // channel a / merged taps
  logic [CW-1:0] coef_b_reg [TN]; // channel b own taps
  // side taps store 16 bits, centre 24;
  // reserved bits read back as written

  // bus slave state
  equalizer_filter_pkg::bus_state_type bus_state_reg;
  logic [AW-1:0] addr_reg; // captured address phase
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic hresp_reg;
  logic addr_phase; // transfer accepted this edge
  logic [31:0] read_data;
  // read data decoded from the captured
  // address, never from the live bus

  // datapath
  logic [TN*SW-1:0] hist_a_reg; // a history, or merged stream history
  logic [TN*SW-1:0] hist_b_reg; // b history in dual mode
  logic [TN*CW-1:0] coef_a_flat;
  logic [TN*CW-1:0] coef_b_flat;
  logic [TN*CW-1:0] coef_b_used;
  logic [TN*SW-1:0] win_a;
  logic [TN*SW-1:0] win_b;
  equalizer_filter_pkg::sample_pair_type result;
  logic accept; // sample pair taken
  logic fifo_in_ready;
  logic [LVL_W-1:0] fifo_level;
  logic filter_active;
  // histories shift only on accepted pairs,
  // so a full FIFO never loses samples

  // storage mask: centre keeps 24 bits, side taps 16 incl. reserved
  // unused upper bits always read zero
  function automatic logic [CW-1:0] coef_mask(input int idx);
    if (idx == equalizer_filter_pkg::CENTRE_TAP) begin
      return equalizer_filter_pkg::CENTRE_REG_MASK;
    end
    return equalizer_filter_pkg::SIDE_REG_MASK;
  endfunction : coef_mask

  // window hit: a word-aligned slot k in base..base+8 words
  function automatic logic coef_hit(input logic [AW-1:0] addr, input logic [AW-1:0] base,
                                    input int k);
    return addr == AW'(base + AW'(k << equalizer_filter_pkg::COEF_STRIDE_SHIFT));
  endfunction : coef_hit

  // window address for channel a tap k, including the printed aliases
  function automatic logic a_tap_hit(input logic [AW-1:0] addr, input int k);
    logic hit;
    hit = coef_hit(addr, equalizer_filter_pkg::COEF_A_BASE, k);
    if (k == 0 && addr == equalizer_filter_pkg::TAP0_ADDR) begin
      hit = 1'b1;
    end
    if (k == 1 && addr == equalizer_filter_pkg::TAP1_ADDR) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : a_tap_hit

  // nine-tap sum with side weighting, rounded toward minus, saturated
  function automatic logic [SW-1:0] fir_sum(input logic [TN*SW-1:0] x,
                                            input logic [TN*CW-1:0] c,
                                            input logic [2:0] w);
    logic signed [equalizer_filter_pkg::ACC_W-1:0] acc;
    logic signed [equalizer_filter_pkg::ACC_W-1:0] xs;
    logic signed [equalizer_filter_pkg::ACC_W-1:0] cs;
    logic signed [equalizer_filter_pkg::ACC_W-1:0] sum;
    // forty bits hold nine products at
    // the largest side weight
    acc = '0;
    for (int k = 0; k < TN; k++) begin
      xs = equalizer_filter_pkg::ACC_W'(signed'(x[k*SW +: SW]));
      if (k == equalizer_filter_pkg::CENTRE_TAP) begin
        // centre tap at 18 bits, lsb 2^-16
        cs = equalizer_filter_pkg::ACC_W'(
          signed'(c[k*CW +: equalizer_filter_pkg::CENTRE_COEF_W]));
        acc = acc + xs * cs;
      end else begin
        // side tap uses only the 12-bit signed field
        cs = equalizer_filter_pkg::ACC_W'(signed'(c[k*CW +: equalizer_filter_pkg::SIDE_COEF_W]));
        acc = acc + ((xs * cs) <<< w);
      end
    end
    // arithmetic shift floors toward minus;
    // cheaper than rounding, half-lsb bias
    sum = acc >>> equalizer_filter_pkg::FRAC_BITS;
    if (sum > equalizer_filter_pkg::SAMPLE_MAX) begin
      sum = equalizer_filter_pkg::ACC_W'(equalizer_filter_pkg::SAMPLE_MAX);
    end else if (sum < equalizer_filter_pkg::SAMPLE_MIN) begin
      sum = equalizer_filter_pkg::ACC_W'(equalizer_filter_pkg::SAMPLE_MIN);
    end
    return sum[SW-1:0];
  endfunction : fir_sum

  // transfer accepted: selected, bus ready, nonseq or seq
  assign addr_phase = hsel && hready && htrans[1];
  // idle and busy both have bit one low,
  // so only real transfers are decoded

  // bus sequencing: writes take no wait, reads one wait state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_state_reg <= equalizer_filter_pkg::bus_idle;
      addr_reg <= '0;
      hreadyout_reg <= 1'b1;
    end else if (addr_phase) begin
      // only the decoded address bits kept
      addr_reg <= haddr[AW-1:0];
      // read data is registered one cycle later, so stall the read
      hreadyout_reg <= hwrite;
      if (hwrite) begin
        bus_state_reg <= equalizer_filter_pkg::bus_write;
      end else begin
        bus_state_reg <= equalizer_filter_pkg::bus_read;
      end
    end else begin
      // no new transfer: release any stall
      hreadyout_reg <= 1'b1;
      bus_state_reg <= equalizer_filter_pkg::bus_idle;
    end
  end

  // read data lands at the end of the wait state; response always okay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_reg <= '0;
      hresp_reg <= 1'b0;
    end else begin
      hresp_reg <= equalizer_filter_pkg::HRESP_OKAY[0];
      // data held otherwise, so a slow
      // master still sees the last word
      case (bus_state_reg)
        equalizer_filter_pkg::bus_read: begin
          hrdata_reg <= read_data;
        end
        default: begin
          hrdata_reg <= hrdata_reg;
        end
      endcase
    end
  end

  // read decode; upper address bits ignored, unmapped reads zero
  always_comb begin
    read_data = '0;
    if (addr_reg == equalizer_filter_pkg::CONFIG_ADDR) begin
      read_data[7:0] = filter_config_reg;
    end else if (addr_reg == equalizer_filter_pkg::STATUS_ADDR) begin
      read_data[equalizer_filter_pkg::STAT_ACTIVE_BIT] = filter_active;
      read_data[equalizer_filter_pkg::STAT_MERGE_BIT] = filter_config_reg.filter_merge_enable;
      read_data[equalizer_filter_pkg::STAT_LINK_BIT] = serial_link_enable;
      read_data[equalizer_filter_pkg::STAT_LEVEL_LSB +: LVL_W] = fifo_level;
    end else begin
      // coefficient windows; a and b never overlap
      for (int k = 0; k < TN; k++) begin
        if (a_tap_hit(addr_reg, k)) begin
          read_data[CW-1:0] = coef_a_reg[k] & coef_mask(k);
        end
        if (coef_hit(addr_reg, equalizer_filter_pkg::COEF_B_BASE, k)) begin
          read_data[CW-1:0] = coef_b_reg[k] & coef_mask(k);
        end
      end
    end
  end

  // configuration write; all eight bits read back as written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_config_reg <= equalizer_filter_pkg::CONFIG_RESET;
    end else if (bus_state_reg == equalizer_filter_pkg::bus_write &&
                 addr_reg == equalizer_filter_pkg::CONFIG_ADDR) begin
      filter_config_reg <= hwdata[7:0];
      // no link-state guard: keeping writes
      // off a live link is software's duty
    end
  end

  // coefficient writes, one generate slot per tap
  for (genvar g = 0; g < TN; g++) begin : g_coef
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        coef_a_reg[g] <= equalizer_filter_pkg::COEF_RESET;
        coef_b_reg[g] <= equalizer_filter_pkg::COEF_RESET;
      end else if (bus_state_reg == equalizer_filter_pkg::bus_write) begin
        if (a_tap_hit(addr_reg, g)) begin
          coef_a_reg[g] <= hwdata[CW-1:0] & coef_mask(g);
        end
        if (coef_hit(addr_reg, equalizer_filter_pkg::COEF_B_BASE, g)) begin
          coef_b_reg[g] <= hwdata[CW-1:0] & coef_mask(g);
        end
      end
    end
    assign coef_a_flat[g*CW +: CW] = coef_a_reg[g];
    assign coef_b_flat[g*CW +: CW] = coef_b_reg[g];
    // flat copies feed the sum function
  end

  // only mode two runs the filter; reserved codes bypass
  assign filter_active =
    (filter_config_reg.filter_mode_select == equalizer_filter_pkg::MODE_ENABLED);
  // reserved codes bypass: the safe
  // choice for an unknown setting

  // share selects the a set for channel b
  assign coef_b_used = filter_config_reg.coef_share_enable ? coef_a_flat : coef_b_flat;

  // stream advances only when the FIFO has room
  assign accept = in_valid && fifo_in_ready;
  // pairs offered while full stay at
  // the source, never dropped here

  // windows: newest sample at slot 0
  // current pair plus history, so the
  // result costs no extra latency
  always_comb begin
    if (filter_config_reg.filter_merge_enable) begin
      // one stream: a precedes b within each pair
      win_a = {hist_a_reg[(TN-1)*SW-1:0], in_data.a};
      win_b = {hist_a_reg[(TN-2)*SW-1:0], in_data.a, in_data.b};
    end else begin
      win_a = {hist_a_reg[(TN-1)*SW-1:0], in_data.a};
      win_b = {hist_b_reg[(TN-1)*SW-1:0], in_data.b};
    end
  end

  // history shift on each accepted pair
  // merged mode leaves b history frozen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_a_reg <= '0;
      hist_b_reg <= '0;
    end else if (accept) begin
      if (filter_config_reg.filter_merge_enable) begin
        // merged history holds both channels interleaved
        hist_a_reg <= {hist_a_reg[(TN-2)*SW-1:0], in_data.a, in_data.b};
      end else begin
        hist_a_reg <= win_a;
        hist_b_reg <= win_b;
      end
    end
  end

  // one result per pair, bypass when disabled
  always_comb begin
    if (filter_active) begin
      // merged filter uses the a coefficient set
      result.a = fir_sum(win_a, coef_a_flat, filter_config_reg.side_coef_weight);
      if (filter_config_reg.filter_merge_enable) begin
        result.b = fir_sum(win_b, coef_a_flat, filter_config_reg.side_coef_weight);
      end else begin
        result.b = fir_sum(win_b, coef_b_used, filter_config_reg.side_coef_weight);
      end
    end else begin
      // bypass: pair passes unchanged
      result = in_data;
    end
  end

  // output buffer; its full flag stalls the input stream
  // depth sets how long a consumer may
  // stall before the source is held off
  sample_fifo #(
    .WIDTH(2*SW),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(in_valid),
    .in_data(result),
    .in_ready(fifo_in_ready),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_ready(out_ready),
    .level(fifo_level)
  );

  // bus outputs leave from registers
  assign in_ready = fifo_in_ready;
  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = hresp_reg;
endmodule : programmable_fir_equalizer_cfg
`default_nettype wire

// *** bench/programmable_fir_equalizer_cfg_sva.sv ***
// fir_cfg_checker: bus timing and stream flow seen at the block's ports.
// assumes hready is fed back from hreadyout, one slave on the bus.
`timescale 1ns/1ns
`default_nettype none
module fir_cfg_checker #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // stream
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire equalizer_filter_pkg::sample_pair_type out_data,
  input wire logic out_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_take; // read address phase taken
  logic wr_take; // write address phase taken
  int held; // pairs inside, from handshakes alone
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  // occupancy from both handshakes, independent of the fifo's own flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held <= 0;
    end else begin
      held <= held + int'(in_valid && in_ready) - int'(out_valid && out_ready);
    end
  end
  AST_HRESP_OKAY:
    assert property (hresp == 1'b0) else $error("bus response not okay");
  AST_WRITE_NO_WAIT:
    assert property (wr_take |=> hreadyout) else $error("write was stalled");
  AST_READ_ONE_WAIT:
    assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  AST_WAIT_ONLY_READ:
    assert property (!hreadyout |-> $past(rd_take)) else $error("stall without read");
  AST_RDATA_HOLDS:
    assert property (!$stable(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
  AST_OUT_HOLDS:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output dropped before pop");
  AST_IN_READY_FULL:
    assert property (!$past(rst) |-> in_ready == (held < FIFO_DEPTH))
      else $error("input ready does not match fill");
  AST_OUT_VALID_FILL:
    assert property (!$past(rst) |-> out_valid == (held != 0))
      else $error("output valid does not match fill");
endmodule : fir_cfg_checker
bind programmable_fir_equalizer_cfg fir_cfg_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
`default_nettype wire

// *** bench/adc_sample_source.sv ***
// adc_sample_source: sampling-core stand-in offering a/b sample pairs.
// assumes a pair is taken at an edge where in_valid and in_ready are high.
`timescale 1ns/1ns
`default_nettype none
module adc_sample_source (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // stream toward the block
  output logic in_valid,
  output equalizer_filter_pkg::sample_pair_type in_data,
  input wire logic in_ready
);
  equalizer_filter_pkg::sample_pair_type pend[$]; // pairs still to offer
  int gap = 0; // idle cycles after each pair, slow mode
  int idle = 0; // idle cycles left
  // queue one pair
  task automatic put(input equalizer_filter_pkg::sample_pair_type p);
    pend.push_back(p);
  endtask : put
  // offer held until taken; idle data toggles so a stale pair never matches
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_valid <= 1'b0;
      in_data <= '0;
    end else if (!in_valid || in_ready) begin
      if (pend.size() != 0 && idle == 0) begin
        in_valid <= 1'b1;
        in_data <= pend.pop_front();
        idle <= gap;
      end else begin
        in_valid <= 1'b0;
        in_data <= ~in_data;
        if (idle != 0) idle <= idle - 1;
      end
    end
  end
endmodule : adc_sample_source
`default_nettype wire

// *** bench/programmable_fir_equalizer_cfg_bench.sv ***
// programmable_fir_equalizer_cfg_bench: register, filter and fifo scenarios.
// assumes the sample source model and a bus master made of tasks.
`timescale 1ns/1ns
`default_nettype none
module programmable_fir_equalizer_cfg_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, in_valid, in_ready, out_valid;
  logic [31:0] hrdata, rd;
  logic out_ready = 1'b1; // consumer, stalled in the fifo scenario
  logic link_en = 1'b0; // serial link state
  equalizer_filter_pkg::sample_pair_type in_data, out_data;
  equalizer_filter_pkg::sample_pair_type got[$]; // popped pairs
  int bad_count = 0;
  int n_tests = 0;
  int taken = 0; // pairs accepted
  int sa[6] = '{100, -3, 2047, -2048, 5, -1}; // channel a samples
  int sb[6] = '{7, 300, -2048, 1, -77, 2047}; // channel b samples
  always #50 clk = ~clk;
  programmable_fir_equalizer_cfg uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .in_valid(in_valid),
    .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .serial_link_enable(link_en));
  adc_sample_source src (.clk(clk), .rst(rst), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready));
  // collect popped pairs, count accepted ones
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
    if (in_valid === 1'b1 && in_ready === 1'b1) taken++;
  end
  // verdict, the one place the run ends
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : check
  // one single transfer; waits on hready with a bound
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {16'h0, a};
    hwrite <= wr;
    htrans <= equalizer_filter_pkg::HTRANS_NONSEQ;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 40);
    rd = hrdata;
    hsel <= 1'b0;
    if (k >= 20) begin bad_count++; test_done(); end
  endtask : bus
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk
  task automatic wait_out(input int n);
    for (int k = 0; k < 500 && got.size() < n; k++) @(posedge clk);
    if (got.size() < n) begin bad_count++; test_done(); end
  endtask : wait_out
  // reference: two side taps, weighted, floored, saturated
  function automatic int fir(input int x0, x1, c0, c1, w);
    int s;
    s = ((x0 * c0 + x1 * c1) <<< w) >>> equalizer_filter_pkg::FRAC_BITS;
    if (s > equalizer_filter_pkg::SAMPLE_MAX) s = equalizer_filter_pkg::SAMPLE_MAX;
    if (s < equalizer_filter_pkg::SAMPLE_MIN) s = equalizer_filter_pkg::SAMPLE_MIN;
    return s;
  endfunction : fir
  // configure, stream the table, compare from the second pair on
  task automatic run(input logic [7:0] cfg, input int c0, input int c1);
    int ea, eb, w;
    w = int'(cfg[4:2]);
    link_en <= 1'b0;
    bus(1'b1, equalizer_filter_pkg::TAP0_ADDR, {20'h0, c0[11:0]});
    bus(1'b1, equalizer_filter_pkg::TAP1_ADDR, {20'h0, c1[11:0]});
    bus(1'b1, equalizer_filter_pkg::CONFIG_ADDR, {24'h0, cfg});
    got.delete();
    for (int k = 0; k < 6; k++) src.put({sb[k][11:0], sa[k][11:0]});
    wait_out(6);
    for (int k = 1; k < 6; k++) begin
      if (cfg[1:0] != equalizer_filter_pkg::MODE_ENABLED) begin
        ea = sa[k];
        eb = sb[k];
      end else if (cfg[5]) begin
        ea = fir(sa[k], sb[k-1], c0, c1, w);
        eb = fir(sb[k], sa[k], c0, c1, w);
      end else begin
        ea = fir(sa[k], sa[k-1], c0, c1, w);
        eb = cfg[6] ? fir(sb[k], sb[k-1], c0, c1, w) : 0;
      end
      check({8'h0, got[k]}, {8'h0, eb[11:0], ea[11:0]});
    end
  endtask : run
  task automatic t_regs;
    rdchk(equalizer_filter_pkg::CONFIG_ADDR, 32'h0);
    rdchk(equalizer_filter_pkg::TAP0_ADDR, 32'h0);
    rdchk(equalizer_filter_pkg::TAP1_ADDR, 32'h0);
    bus(1'b1, equalizer_filter_pkg::CONFIG_ADDR, 32'hffffffff);
    rdchk(equalizer_filter_pkg::CONFIG_ADDR, 32'hff);
    bus(1'b1, equalizer_filter_pkg::TAP0_ADDR, 32'hffffffff);
    rdchk(equalizer_filter_pkg::COEF_A_BASE, 32'hffff);
    bus(1'b1, equalizer_filter_pkg::TAP1_ADDR, 32'h12345a5a);
    rdchk(equalizer_filter_pkg::TAP1_ADDR, 32'h5a5a);
    bus(1'b1, equalizer_filter_pkg::COEF_A_BASE + 16'h10, 32'hffffffff);
    rdchk(equalizer_filter_pkg::COEF_A_BASE + 16'h10, 32'hffffff);
    bus(1'b1, equalizer_filter_pkg::COEF_A_BASE + 16'h10, 32'h0);
    bus(1'b1, equalizer_filter_pkg::COEF_B_BASE, 32'h00abcdef);
    rdchk(equalizer_filter_pkg::COEF_B_BASE, 32'hcdef);
    bus(1'b1, equalizer_filter_pkg::COEF_B_BASE, 32'h0);
    bus(1'b1, 16'h1ffc, 32'hffffffff);
    rdchk(16'h1ffc, 32'h0);
  endtask : t_regs
  // disabled and reserved codes pass samples through
  task automatic t_bypass;
    run(8'h18, 1024, 0);
    run(8'h19, 1024, 0);
    run(8'h1b, 1024, 0);
  endtask : t_bypass
  task automatic t_share;
    run(8'h5a, 1024, 0);
    run(8'h1a, 1024, 0);
    run(8'h1a, 0, 1024);
  endtask : t_share
  task automatic t_weight;
    run(8'h16, 1024, 0);
    run(8'h02, 2047, 0);
    run(8'h1a, -1024, 0);
  endtask : t_weight
  task automatic t_merge;
    run(8'h3a, 512, 1024);
    link_en <= 1'b1;
    rdchk(equalizer_filter_pkg::STATUS_ADDR, 32'h7);
  endtask : t_merge
  // fill against a stalled consumer, then drain in order
  task automatic t_fifo;
    int k;
    link_en <= 1'b0;
    bus(1'b1, equalizer_filter_pkg::CONFIG_ADDR, 32'h0);
    out_ready <= 1'b0;
    got.delete();
    taken = 0;
    src.gap = 1;
    for (k = 0; k < 10; k++) src.put({sb[k%6][11:0], sa[k%6][11:0]});
    for (k = 0; k < 60 && (taken < 8 || in_ready !== 1'b0); k++) @(negedge clk);
    repeat (4) @(negedge clk);
    check(taken, 8);
    check(got.size(), 0);
    @(posedge clk);
    out_ready <= 1'b1;
    wait_out(10);
    for (k = 0; k < 10; k++) check({8'h0, got[k]}, {8'h0, sb[k%6][11:0], sa[k%6][11:0]});
    src.gap = 0;
  endtask : t_fifo
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_bypass();
    t_share();
    t_weight();
    t_merge();
    t_fifo();
    test_done();
  end
endmodule : programmable_fir_equalizer_cfg_bench
`default_nettype wire
